// File: hdl/gpio_port.sv
// eight-pin bidirectional port with direction, output latch and analog select
// assumes a register master that never waits and pins that resolve oe_n externally
//
// Our own choices: the plain strobed port and the address map.

// Behaviour
// - eight pins, each with direction, data, analog
// - direction one makes pin a tristated input
// - direction zero drives latch value onto pin
// - read returns pin levels, write sets latch
// - single-bit updates are read-modify-write on pin levels
// - direction controls drivers even on analog pins
// - analog pins always read as zero
// - analog select disables digital input buffer
// - analog select changes digital output only through single-bit updates
// - absent port: registers read zero, unimplemented
// - each pin selectable as touch sense input
// - reset sets direction and analog to ones
module gpio_port
#(
   parameter bit PORT_PRESENT = 1'b1
)
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   // port pins
   input  wire logic [7:0] pin_in,
   output logic      [7:0] pin_out,
   output logic      [7:0] pin_oe_n,
   // analog side
   output logic      [7:0] analog_enable,
   output logic      [7:0] touch_sense_enable
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic reset_meta_n;
   logic rst_n_sync;

   // release is delayed two edges so no flop sees a ragged deassertion
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reset_meta_n <= 1'b0;
         rst_n_sync   <= 1'b0;
      end
      else
      begin
         reset_meta_n <= 1'b1;
         rst_n_sync   <= reset_meta_n;
      end
   end

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [7:0] port_output_latch;
   logic [7:0] port_direction;
   logic [7:0] port_analog_select;
   logic [3:0] touch_select;
   logic [7:0] pin_level_sync;
   logic [7:0] digital_level;
   logic [7:0] next_latch;
   logic [7:0] touch_onehot;

   logic wr_data;
   logic wr_direction;
   logic wr_analog;
   logic wr_touch;
   logic wr_bit;

   // an absent port takes no writes at all
   assign wr_data      = PORT_PRESENT && reg_write
                         && (reg_addr == gpio_port_pkg::OFFSET_PIN_DATA);
   assign wr_direction = PORT_PRESENT && reg_write
                         && (reg_addr == gpio_port_pkg::OFFSET_DIRECTION);
   assign wr_analog    = PORT_PRESENT && reg_write
                         && (reg_addr == gpio_port_pkg::OFFSET_ANALOG_SELECT);
   assign wr_touch     = PORT_PRESENT && reg_write
                         && (reg_addr == gpio_port_pkg::OFFSET_TOUCH_SELECT);
   assign wr_bit       = PORT_PRESENT && reg_write
                         && (reg_addr == gpio_port_pkg::OFFSET_PIN_BIT_UPDATE);

   // ----------------------------------------------------------------
   // pin input path
   // ----------------------------------------------------------------
   pin_sync u_pin_sync
   (
      .mclk           (mclk),
      .rst_n          (rst_n_sync),
      .pin_level_raw  (pin_in),
      .pin_level_sync (pin_level_sync)
   );

   // analog pins have their digital input buffer off, so they read low
   assign digital_level = pin_level_sync & ~port_analog_select;

   // ----------------------------------------------------------------
   // output latch, read-modify-write
   // ----------------------------------------------------------------
   // the modification starts from the pin levels, not from the latch;
   // an output pin held by a strong load or set analog can flip its
   // latch bit on a single-bit update, just as the real port does
   always_comb
   begin
      next_latch = digital_level;
      if (wr_data)
         next_latch = reg_wdata;
      else if (wr_bit)
         next_latch[reg_wdata[gpio_port_pkg::BIT_INDEX_MSB:gpio_port_pkg::BIT_INDEX_LSB]]
            = reg_wdata[gpio_port_pkg::BIT_VALUE_POS];
   end

   // the latch content after reset is undefined to software; zero is chosen
   always_ff @(posedge mclk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
         port_output_latch <= gpio_port_pkg::LATCH_RESET;
      else if (wr_data || wr_bit)
         port_output_latch <= next_latch;
   end

   // ----------------------------------------------------------------
   // direction and analog select
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
         port_direction <= gpio_port_pkg::DIRECTION_RESET;
      else if (wr_direction)
         port_direction <= reg_wdata;
   end

   always_ff @(posedge mclk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
         port_analog_select <= gpio_port_pkg::ANALOG_SELECT_RESET;
      else if (wr_analog)
         port_analog_select <= reg_wdata;
   end

   always_ff @(posedge mclk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
         touch_select <= gpio_port_pkg::TOUCH_SELECT_RESET;
      else if (wr_touch)
         touch_select <= reg_wdata[3:0];
   end

   // ----------------------------------------------------------------
   // pin drivers, per pin
   // ----------------------------------------------------------------
   for (genvar i = 0; i < gpio_port_pkg::PORT_WIDTH; i++)
   begin : g_pin
      // analog select is not in this path: drivers follow direction only
      assign pin_oe_n[i] = PORT_PRESENT ? port_direction[i] : 1'b1;
      assign pin_out[i]  = port_output_latch[i];
      assign analog_enable[i] = PORT_PRESENT && port_analog_select[i];
      assign touch_onehot[i]  = (touch_select[gpio_port_pkg::TOUCH_CHAN_MSB:
                                              gpio_port_pkg::TOUCH_CHAN_LSB] == 3'(i));
      // a pin joins the touch oscillator only while it is analog
      assign touch_sense_enable[i] = analog_enable[i] && touch_onehot[i]
                                     && touch_select[gpio_port_pkg::TOUCH_ENABLE_POS];
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // read data stand in the cycle after the strobe only
   always_ff @(posedge mclk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
         reg_rdata <= gpio_port_pkg::ALL_ZERO;
      else if (reg_read && PORT_PRESENT)
      begin
         case (reg_addr)
            gpio_port_pkg::OFFSET_PIN_DATA:      reg_rdata <= digital_level;
            gpio_port_pkg::OFFSET_DIRECTION:     reg_rdata <= port_direction;
            gpio_port_pkg::OFFSET_ANALOG_SELECT: reg_rdata <= port_analog_select;
            gpio_port_pkg::OFFSET_TOUCH_SELECT:  reg_rdata <= {4'h0, touch_select};
            default:                             reg_rdata <= gpio_port_pkg::ALL_ZERO;
         endcase
      end
      else
         reg_rdata <= gpio_port_pkg::ALL_ZERO;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n_sync);

   logic [7:0] past_level_1;
   logic [7:0] past_level_2;

   // pin history two edges back, for the synchroniser delay check
   always_ff @(posedge mclk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
      begin
         past_level_1 <= gpio_port_pkg::ALL_ZERO;
         past_level_2 <= gpio_port_pkg::ALL_ZERO;
      end
      else
      begin
         past_level_1 <= pin_in;
         past_level_2 <= past_level_1;
      end
   end

   logic [1:0] sync_age;

   always_ff @(posedge mclk or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
         sync_age <= 2'h0;
      else if (sync_age != 2'h3)
         sync_age <= sync_age + 2'h1;
   end

   chk_sync_two_stages: assert property (
      (sync_age == 2'h3) |-> (pin_level_sync == past_level_2))
      else $error("pin level does not lag pin input by two cycles");

   chk_direction_drives_oe: assert property (
      wr_direction |=> (pin_oe_n == $past(reg_wdata)))
      else $error("output enables do not follow written direction");

   chk_latch_on_pins: assert property (
      wr_data |=> (pin_out == $past(reg_wdata))
                  ##1 ((pin_out == $past(pin_out)) || $past(wr_data) || $past(wr_bit)))
      else $error("written latch value not driven on pins");

   chk_read_pin_levels: assert property (
      (reg_read && (reg_addr == gpio_port_pkg::OFFSET_PIN_DATA))
      |=> (reg_rdata == ($past(pin_level_sync) & ~$past(port_analog_select))))
      else $error("pin data read does not return pin levels");

   chk_bit_update_rmw: assert property (
      wr_bit |=> ((port_output_latch
                   & ~(8'h01 << $past(reg_wdata[2:0])))
                  == ($past(digital_level) & ~(8'h01 << $past(reg_wdata[2:0])))))
      else $error("bit update did not start from the pin levels");

   chk_analog_keeps_drive: assert property (
      (wr_analog && PORT_PRESENT) |=> (pin_oe_n == $past(pin_oe_n)))
      else $error("analog select write changed the output drivers");

   chk_analog_reads_zero: assert property (
      (reg_read && (reg_addr == gpio_port_pkg::OFFSET_PIN_DATA)
       && (port_analog_select == gpio_port_pkg::ALL_ONE))
      |=> (reg_rdata == gpio_port_pkg::ALL_ZERO))
      else $error("analog pins did not read as zero");

   chk_reset_all_analog: assert property (
      $rose(reset_meta_n) |-> ##1 ((port_direction == gpio_port_pkg::DIRECTION_RESET)
                                  && (port_analog_select == gpio_port_pkg::ANALOG_SELECT_RESET)))
      else $error("direction or analog select not all ones after reset");

   chk_absent_reads_zero: assert property (
      (!PORT_PRESENT && reg_read) |=> (reg_rdata == gpio_port_pkg::ALL_ZERO))
      else $error("absent port returned nonzero read data");

   chk_touch_needs_analog: assert property (
      ((touch_sense_enable & ~port_analog_select) == gpio_port_pkg::ALL_ZERO)
      and ($countones(touch_sense_enable) <= 1))
      else $error("touch sense on a digital pin or on several pins");

   chk_read_one_cycle: assert property (
      (!reg_read && PORT_PRESENT) |=> (reg_rdata == gpio_port_pkg::ALL_ZERO))
      else $error("read data stood beyond the answer cycle");

   cov_byte_write_then_read: cover property (
      wr_data ##1 (reg_read && (reg_addr == gpio_port_pkg::OFFSET_PIN_DATA)));

   cov_bit_update_output: cover property (
      wr_bit && (port_direction != gpio_port_pkg::ALL_ONE));

   cov_analog_output_pin: cover property (
      ((port_analog_select & ~port_direction) != gpio_port_pkg::ALL_ZERO));

   cov_touch_active: cover property (
      (touch_sense_enable != gpio_port_pkg::ALL_ZERO));

endmodule

// File: hdl/gpio_port_pkg.sv
// constants shared by the eight-pin port and its pin synchroniser
// assumes a single 200 MHz system clock and a small byte-wide register port
package gpio_port_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int PORT_WIDTH = 8;
   localparam int ADDR_WIDTH = 3;
   localparam int SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [2:0] OFFSET_PIN_DATA       = 3'h0;
   localparam logic [2:0] OFFSET_DIRECTION      = 3'h1;
   localparam logic [2:0] OFFSET_ANALOG_SELECT  = 3'h2;
   localparam logic [2:0] OFFSET_TOUCH_SELECT   = 3'h3;
   localparam logic [2:0] OFFSET_PIN_BIT_UPDATE = 3'h4;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_INDEX_LSB    = 0;
   localparam int BIT_INDEX_MSB    = 2;
   localparam int BIT_VALUE_POS    = 3;
   localparam int TOUCH_CHAN_LSB   = 0;
   localparam int TOUCH_CHAN_MSB   = 2;
   localparam int TOUCH_ENABLE_POS = 3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] DIRECTION_RESET     = 8'hff;
   localparam logic [7:0] ANALOG_SELECT_RESET = 8'hff;
   localparam logic [7:0] LATCH_RESET         = 8'h00;
   localparam logic [3:0] TOUCH_SELECT_RESET  = 4'h0;
   localparam logic [7:0] ALL_ZERO            = 8'h00;
   localparam logic [7:0] ALL_ONE             = 8'hff;

endpackage

// File: hdl/pin_sync.sv
// two-stage synchroniser for the eight port pin levels
// assumes pins change asynchronously to mclk; reset already synchronised
module pin_sync
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // pins in, synchronised levels out
   input  wire logic [7:0] pin_level_raw,
   output logic      [7:0] pin_level_sync
);

   // ----------------------------------------------------------------
   // one pair of flops per pin
   // ----------------------------------------------------------------
   logic [7:0] stage_first;

   for (genvar i = 0; i < gpio_port_pkg::PORT_WIDTH; i++)
   begin : g_bit
      // the first stage feeds only the second one
      always_ff @(posedge mclk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            stage_first[i]    <= 1'b0;
            pin_level_sync[i] <= 1'b0;
         end
         else
         begin
            stage_first[i]    <= pin_level_raw[i];
            pin_level_sync[i] <= stage_first[i];
         end
      end
   end

endmodule

// File: verif/pin_world.sv
// external circuitry on the eight port pins: bench drivers, contention, floating
// assumes the bench changes ext_value and ext_drive just after a rising mclk edge
module pin_world
(
   // clock
   input  wire logic       mclk,
   // device side
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   // bench side
   input  wire logic [7:0] ext_value,
   input  wire logic [7:0] ext_drive,
   // resolved wire levels
   output logic      [7:0] pin_level
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] float_level = 8'h55;

   // a floating pin keeps changing, so a read of an undriven input never matches by luck
   always @(posedge mclk)
   begin
      float_level <= ~float_level;
   end

   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (!pin_oe_n[i] && ext_drive[i])
            pin_level[i] = 1'bx;
         else if (!pin_oe_n[i])
            pin_level[i] = pin_out[i];
         else if (ext_drive[i])
            pin_level[i] = ext_value[i];
         else
            pin_level[i] = float_level[i];
      end
   end
endmodule

// File: verif/testbench.sv
// self-checking bench: register tasks, a pin model and a port variant without registers
// assumes gpio_port_pkg, gpio_port and pin_world are compiled first
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic       mclk = 1'b0;
   logic       reset_n = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic [7:0] ext_value = 8'h00;
   logic [7:0] ext_drive = 8'h00;
   logic [7:0] reg_rdata, absent_rdata, pin_level, pin_out, pin_oe_n;
   logic [7:0] analog_enable, touch_sense_enable;
   int         n_mismatch = 0;
   int         n_compared = 0;
   int         cycles = 0;

   gpio_port #(.PORT_PRESENT(1'b1)) i_dut (.mclk(mclk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .pin_in(pin_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .analog_enable(analog_enable), .touch_sense_enable(touch_sense_enable));
   gpio_port #(.PORT_PRESENT(1'b0)) i_absent (.mclk(mclk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(absent_rdata), .pin_in(pin_level), .pin_out(), .pin_oe_n(),
      .analog_enable(), .touch_sense_enable());
   pin_world i_pins (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_value(ext_value), .ext_drive(ext_drive), .pin_level(pin_level));

   always #2.5 mclk = ~mclk;

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_write <= 1'b0;
      #1;
   endtask

   // the variant without the port must answer zero to every read
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1;
      check(reg_rdata, exp);
      check(absent_rdata, 8'h00);
   endtask

   // pins reach reads after two synchroniser stages, three edges leave margin
   task automatic pins(input logic [7:0] v, input logic [7:0] drv);
      @(posedge mclk);
      ext_value <= v;
      ext_drive <= drv;
      repeat (3) @(posedge mclk);
   endtask

   // ----------------------------------------------------------------
   // hang guard: the tests need about 110 cycles
   // ----------------------------------------------------------------
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         $display("[ERR] %0t timeout", $time);
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      check(pin_oe_n, 8'hff);
      check(analog_enable, 8'hff);
      rd(gpio_port_pkg::OFFSET_DIRECTION, 8'hff);
      rd(gpio_port_pkg::OFFSET_ANALOG_SELECT, 8'hff);
      pins(8'h5a, 8'hff);
      rd(gpio_port_pkg::OFFSET_PIN_DATA, 8'h00);
      $display("test reset done");

      wr(gpio_port_pkg::OFFSET_ANALOG_SELECT, 8'h00);
      check(analog_enable, 8'h00);
      rd(gpio_port_pkg::OFFSET_PIN_DATA, 8'h5a);
      @(posedge mclk);
      ext_value <= 8'hc3;
      rd(gpio_port_pkg::OFFSET_PIN_DATA, 8'h5a);
      rd(gpio_port_pkg::OFFSET_PIN_DATA, 8'hc3);
      wr(gpio_port_pkg::OFFSET_PIN_DATA, 8'h3c);
      check(pin_out, 8'h3c);
      check(pin_oe_n, 8'hff);
      rd(gpio_port_pkg::OFFSET_PIN_DATA, 8'hc3);
      $display("test input done");

      pins(8'h00, 8'h00);
      wr(gpio_port_pkg::OFFSET_DIRECTION, 8'h00);
      check(pin_oe_n, 8'h00);
      check(pin_out, 8'h3c);
      pins(8'h00, 8'h00);
      rd(gpio_port_pkg::OFFSET_PIN_DATA, 8'h3c);
      wr(gpio_port_pkg::OFFSET_PIN_DATA, 8'ha5);
      wr(gpio_port_pkg::OFFSET_ANALOG_SELECT, 8'h0f);
      check(pin_oe_n, 8'h00);
      check(pin_out, 8'ha5);
      check(analog_enable, 8'h0f);
      pins(8'h00, 8'h00);
      rd(gpio_port_pkg::OFFSET_PIN_DATA, 8'ha0);
      wr(gpio_port_pkg::OFFSET_PIN_BIT_UPDATE, 8'h07);
      check(pin_out, 8'h20);
      pins(8'h00, 8'h00);
      wr(gpio_port_pkg::OFFSET_PIN_BIT_UPDATE, 8'h08);
      check(pin_out, 8'h21);
      wr(gpio_port_pkg::OFFSET_DIRECTION, 8'hf0);
      check(pin_oe_n, 8'hf0);
      $display("test output done");

      // analog pins kept as inputs while routed to the touch oscillator
      wr(gpio_port_pkg::OFFSET_DIRECTION, 8'hff);
      wr(gpio_port_pkg::OFFSET_ANALOG_SELECT, 8'hff);
      for (int i = 0; i < 8; i++)
      begin
         wr(gpio_port_pkg::OFFSET_TOUCH_SELECT, 8'h08 | 8'(i));
         check(touch_sense_enable, 8'h01 << i);
      end
      wr(gpio_port_pkg::OFFSET_TOUCH_SELECT, 8'h02);
      check(touch_sense_enable, 8'h00);
      $display("test touch done");

      for (int a = 5; a < 8; a++)
      begin
         wr(3'(a), 8'h00);
         rd(3'(a), 8'h00);
      end
      rd(gpio_port_pkg::OFFSET_DIRECTION, 8'hff);
      rd(gpio_port_pkg::OFFSET_PIN_BIT_UPDATE, 8'h00);
      wr(gpio_port_pkg::OFFSET_DIRECTION, 8'h00);
      wr(gpio_port_pkg::OFFSET_ANALOG_SELECT, 8'h00);
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      check(pin_oe_n, 8'hff);
      check(analog_enable, 8'hff);
      $display("test refuse and reset done");
      stop_test();
   end
endmodule
